// ### logic/mtm_defs.vh
// Register offsets, field positions, reset values and timing counts of the modulo timer.
// Assumes inclusion by bare name from the design files.
`ifndef MTM_DEFS_VH
`define MTM_DEFS_VH

`define MTM_ADDR_STATUS_CONTROL   4'h0
`define MTM_ADDR_CLOCK_CONFIG     4'h4
`define MTM_ADDR_COUNT_VALUE      4'h8
`define MTM_ADDR_MODULO_LIMIT     4'hc

`define MTM_BIT_OVERFLOW_FLAG     7
`define MTM_BIT_OVERFLOW_IRQ_EN   6
`define MTM_BIT_COUNTER_RESET     5
`define MTM_BIT_COUNTER_HALT      4
`define MTM_CLKSRC_HI             5
`define MTM_CLKSRC_LO             4
`define MTM_PRESCALE_HI           3
`define MTM_PRESCALE_LO           0

`define MTM_CLKSRC_BUS            2'h0
`define MTM_CLKSRC_FIXED          2'h1
`define MTM_CLKSRC_PIN_FALL       2'h2
`define MTM_CLKSRC_PIN_RISE       2'h3

`define MTM_PRESCALE_MAX          4'h8
`define MTM_RST_CLOCK_CONFIG      8'h00
`define MTM_RST_COUNT             8'h00
`define MTM_RST_MODULO            8'h00
`define MTM_RST_HALT              1'b1
`define MTM_FREE_RUN_LIMIT        8'hff

`endif

// ### logic/mtm_tick_source.v
// Clock-source selector and power-of-two prescaler of the modulo timer.
// Assumes all inputs are synchronous to ref_clk_in except the external pin, synchronised here.
`timescale 1ns/1ps
`include "mtm_defs.vh"

module mtm_tick_source (
    input  wire       ref_clk_in,
    input  wire       rst_in,
    input  wire       clk_en_in,
    input  wire       run_in,
    input  wire [1:0] source_sel_in,
    input  wire [3:0] prescale_sel_in,
    input  wire       fixed_freq_clock_in,
    input  wire       external_count_pin_in,
    output reg        tick_out
);
    reg        pin_meta;
    reg        pin_sync;
    reg        pin_prev;
    reg        fixed_prev;
    reg  [7:0] prescale_count;
    reg        src_pulse;
    reg        next_tick;
    wire [3:0] prescale_eff;

    // Codes above the top divide all fall back to divide by 256
    assign prescale_eff = (prescale_sel_in > `MTM_PRESCALE_MAX) ? `MTM_PRESCALE_MAX
                                                              : prescale_sel_in;

    // Pin is sampled, never used as a clock; edges become one-cycle enables
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_meta   <= 1'b0;
            pin_sync   <= 1'b0;
            pin_prev   <= 1'b0;
            fixed_prev <= 1'b0;
        end else if (clk_en_in) begin
            pin_meta   <= external_count_pin_in;
            pin_sync   <= pin_meta;
            pin_prev   <= pin_sync;
            fixed_prev <= fixed_freq_clock_in;
        end
    end

    always @* begin
        case (source_sel_in)
            `MTM_CLKSRC_BUS:      src_pulse = 1'b1;
            `MTM_CLKSRC_FIXED:    src_pulse = fixed_freq_clock_in & ~fixed_prev;
            `MTM_CLKSRC_PIN_FALL: src_pulse = ~pin_sync & pin_prev;
            `MTM_CLKSRC_PIN_RISE: src_pulse = pin_sync & ~pin_prev;
            default:              src_pulse = 1'b0;
        endcase
    end

    // The prescaler keeps running across selector changes so the count is never disturbed
    always @* begin
        next_tick = 1'b0;
        if (run_in && src_pulse) begin
            if (prescale_eff == 4'h0) begin
                next_tick = 1'b1;
            end else begin
                next_tick = ((prescale_count + 8'h01) & ((8'h01 << prescale_eff) - 8'h01))
                            == 8'h00;
            end
        end
    end

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prescale_count <= 8'h00;
            tick_out       <= 1'b0;
        end else if (clk_en_in) begin
            tick_out <= next_tick;
            if (run_in && src_pulse) begin
                prescale_count <= prescale_count + 8'h01;
            end
        end
    end
endmodule // mtm_tick_source

// ### logic/mtm_modulo_timer.v
// Top of the 8-bit modulo timer with its Avalon-MM register slave.
// Assumes all inputs except the external pin synchronous to ref_clk_in; the debug-mode input is a level from the core.
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mtm_defs.vh"

// Contract
// - Clock-source field is read/write at bits 5:4, reset to 00.
// - Source codes: 00 bus, 01 fixed clock, 10 pin falling, 11 pin rising.
// - Changing the source does not clear the count; counting continues.
// - Prescale field is read/write at bits 3:0, reset to 0000.
// - Codes 0 to 8 divide by 1 to 256; higher codes divide by 256.
// - Changing the prescale does not clear the count; counting continues.
// - Count register is read-only, writes ignored, reset clears it.
// - Modulo register is read/write, resets to zero; zero means free-running.
// - Any modulo write zeroes the count and clears the overflow flag.
// - Modes are stopped, free-running with zero limit, modulo with nonzero limit.
// - After reset: stopped, count zero, limit zero, bus source, divide by one.
// - While running, count up to the limit, then go to zero next tick.
// - Overflow flag sets on the transition from limit to zero.
// - Flag clears by reading status while set, then writing zero, or by a counter-reset write or a modulo write.
// - An overflow between the read and the zero write voids the clear.
// - Writing one to counter-reset also clears the overflow flag.
// - Interrupt request is flag set and interrupt enable set.
// - Writing status with halt cleared starts counting.
// - Halt holds the count; clearing resumes; reset sets halt.
// - Counter-reset is write-only, reads zero; one zeroes count, zero does nothing.
// - Debug mode suspends counting; resume from held value unless reset meanwhile.
module mtm_modulo_timer (
    input  wire        ref_clk_in,
    input  wire        rst_in,
    input  wire        clk_en_in,
    input  wire [3:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    input  wire        fixed_freq_clock_in,
    input  wire        external_count_pin_in,
    input  wire        debug_active_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    output reg         overflow_irq_out,
    output reg  [7:0]  count_value_out
);
    reg        overflow_flag;
    reg        overflow_irq_enable;
    reg        counter_halt_bit;
    reg        clear_armed;
    reg  [1:0] clock_source_select;
    reg  [3:0] prescale_select;
    reg  [7:0] modulo_value;
    reg  [7:0] count;
    reg        answered;
    reg  [7:0] next_read;

    wire       tick;
    wire       access;
    wire       wr_go;
    wire       rd_go;
    wire       lane0;
    wire       sel_sc;
    wire       sel_clk;
    wire       sel_mod;
    wire       counter_run;
    wire       wrap;
    wire       wr_sc;
    wire       counter_reset;
    wire       flag_zero_write;
    wire [7:0] limit;

    localparam [7:0] rst_clk_cfg = `MTM_RST_CLOCK_CONFIG;

    // Each access is answered in its second cycle; waitrequest drops for that one edge
    assign access  = (avs_read_in | avs_write_in) & ~answered;
    assign wr_go   = avs_write_in & answered;
    assign rd_go   = avs_read_in & answered;
    assign lane0   = avs_byteenable_in[0];
    assign sel_sc  = avs_address_in == `MTM_ADDR_STATUS_CONTROL;
    assign sel_clk = avs_address_in == `MTM_ADDR_CLOCK_CONFIG;
    assign sel_mod = avs_address_in == `MTM_ADDR_MODULO_LIMIT;
    assign wr_sc   = wr_go & lane0 & sel_sc;

    assign counter_run   = ~counter_halt_bit & ~debug_active_in;
    assign limit         = (modulo_value == 8'h00) ? `MTM_FREE_RUN_LIMIT
                                                   : modulo_value;
    assign wrap          = tick & counter_run & (count == limit);
    assign counter_reset = (wr_sc & avs_writedata_in[`MTM_BIT_COUNTER_RESET])
                           | (wr_go & lane0 & sel_mod);
    assign flag_zero_write = wr_sc & ~avs_writedata_in[`MTM_BIT_OVERFLOW_FLAG];

    mtm_tick_source u_tick_source (
        .ref_clk_in            (ref_clk_in),
        .rst_in                (rst_in),
        .clk_en_in             (clk_en_in),
        .run_in                (counter_run),
        .source_sel_in         (clock_source_select),
        .prescale_sel_in       (prescale_select),
        .fixed_freq_clock_in   (fixed_freq_clock_in),
        .external_count_pin_in (external_count_pin_in),
        .tick_out              (tick)
    );

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            answered            <= 1'b0;
            avs_waitrequest_out <= 1'b1;
        end else if (clk_en_in) begin
            answered            <= access;
            avs_waitrequest_out <= ~access;
        end
    end

    // Count: a software reset beats a tick in the same cycle
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= `MTM_RST_COUNT;
        end else if (clk_en_in) begin
            if (counter_reset) begin
                count <= 8'h00;
            end else if (wrap) begin
                count <= 8'h00;
            end else if (tick & counter_run) begin
                count <= count + 8'h01;
            end
        end
    end

    // Flag: a new overflow wins over a zero write and disarms the pending clear
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            overflow_flag <= 1'b0;
            clear_armed   <= 1'b0;
        end else if (clk_en_in) begin
            if (counter_reset) begin
                overflow_flag <= 1'b0;
                clear_armed   <= 1'b0;
            end else if (wrap) begin
                overflow_flag <= 1'b1;
                clear_armed   <= 1'b0;
            end else if (flag_zero_write && clear_armed) begin
                overflow_flag <= 1'b0;
                clear_armed   <= 1'b0;
            end else if (rd_go && sel_sc && overflow_flag) begin
                clear_armed <= 1'b1;
            end
        end
    end

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            overflow_irq_enable <= 1'b0;
            counter_halt_bit    <= `MTM_RST_HALT;
            clock_source_select <= rst_clk_cfg[`MTM_CLKSRC_HI:`MTM_CLKSRC_LO];
            prescale_select     <= rst_clk_cfg[`MTM_PRESCALE_HI:`MTM_PRESCALE_LO];
            modulo_value        <= `MTM_RST_MODULO;
        end else if (clk_en_in) begin
            if (wr_sc) begin
                overflow_irq_enable <= avs_writedata_in[`MTM_BIT_OVERFLOW_IRQ_EN];
                counter_halt_bit    <= avs_writedata_in[`MTM_BIT_COUNTER_HALT];
            end
            if (wr_go && lane0 && sel_clk) begin
                clock_source_select <= avs_writedata_in[`MTM_CLKSRC_HI:`MTM_CLKSRC_LO];
                prescale_select     <= avs_writedata_in[`MTM_PRESCALE_HI:`MTM_PRESCALE_LO];
            end
            if (wr_go && lane0 && sel_mod) begin
                modulo_value <= avs_writedata_in[7:0];
            end
        end
    end

    // Counter-reset bit and bits 7:6 of clock config always read zero
    always @* begin
        case (avs_address_in)
            `MTM_ADDR_STATUS_CONTROL: next_read = {overflow_flag, overflow_irq_enable, 1'b0,
                                                   counter_halt_bit, 4'h0};
            `MTM_ADDR_CLOCK_CONFIG:   next_read = {2'h0, clock_source_select, prescale_select};
            `MTM_ADDR_COUNT_VALUE:    next_read = count;
            `MTM_ADDR_MODULO_LIMIT:   next_read = modulo_value;
            default:                  next_read = 8'h00;
        endcase
    end

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h0000_0000;
            overflow_irq_out <= 1'b0;
            count_value_out  <= 8'h00;
        end else if (clk_en_in) begin
            if (avs_read_in && access) begin
                avs_readdata_out <= {24'h00_0000, next_read};
            end
            overflow_irq_out <= overflow_flag & overflow_irq_enable;
            count_value_out  <= count;
        end
    end
endmodule // mtm_modulo_timer

// ### test/mtm_modulo_timer_asserts.sv
// Port-level assertions of the modulo timer, bound to its top module.
// Assumes clk_en_in high whenever the bus is busy, and the irq enable never set over a set flag.
`timescale 1ns/1ps
module mtm_chk (
    input wire        ref_clk_in,
    input wire        rst_in,
    input wire [3:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0]  avs_byteenable_in,
    input wire        debug_active_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    input wire        overflow_irq_out,
    input wire [7:0]  count_value_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    wire ack  = !avs_waitrequest_out;
    wire rack = avs_read_in && ack;
    // Five cycles cover the tick, count and copy stages
    sequence s_frozen;
        (debug_active_in && !avs_write_in) [*5];
    endsequence
    sequence s_clr;
        avs_write_in && ack && avs_byteenable_in[0] && (avs_address_in == 4'hc
            || (avs_address_in == 4'h0 && avs_writedata_in[5]));
    endsequence
    property p_ack_once; ack |=> !ack; endproperty
    a_ack_once: assert property (p_ack_once) else $error("wait low too long");
    property p_answer; (avs_read_in || avs_write_in) && !ack |=> ack; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_step;
        $changed(count_value_out) |-> count_value_out == $past(count_value_out) + 8'h01
            || count_value_out == 8'h00;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
    property p_frozen; s_frozen |-> $stable(count_value_out); endproperty
    a_frozen: assert property (p_frozen) else $error("count moved in debug");
    property p_clr; s_clr |-> ##2 (count_value_out == 8'h00 && !overflow_irq_out); endproperty
    a_clr: assert property (p_clr) else $error("clear missed");
    property p_irq; $rose(overflow_irq_out) |-> count_value_out == 8'h00; endproperty
    a_irq: assert property (p_irq) else $error("irq without wrap");
    property p_unmap; rack && avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_sts;
        rack && avs_address_in == 4'h0 |-> !avs_readdata_out[5] && avs_readdata_out[3:0] == 4'h0;
    endproperty
    a_sts: assert property (p_sts) else $error("status spare bits set");
    property p_cfg; rack && avs_address_in == 4'h4 |-> avs_readdata_out[31:6] == 26'h0; endproperty
    a_cfg: assert property (p_cfg) else $error("config upper bits set");
endmodule // mtm_chk

bind mtm_modulo_timer mtm_chk u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .debug_active_in(debug_active_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .overflow_irq_out(overflow_irq_out),
    .count_value_out(count_value_out));

// ### test/mtm_modulo_timer_tb.sv
// Self-checking bench of the modulo timer through its Avalon-MM slave.
// Assumes the checker is bound separately; clk_en_in drops only while the bus is idle.
`timescale 1ns/1ps
module mtm_modulo_timer_tb;
    reg         ref_clk_in = 1'b0;
    reg         rst_in     = 1'b1;
    reg  [3:0]  adr        = 4'h0;
    reg         rd         = 1'b0;
    reg         wr         = 1'b0;
    reg  [7:0]  wd         = 8'h00;
    reg  [3:0]  be         = 4'hf;
    reg         dbg        = 1'b0;
    reg         ce         = 1'b1;
    reg  [3:0]  ph         = 4'h0;
    reg  [7:0]  v          = 8'h00;
    wire [31:0] rdat;
    wire        wreq;
    wire        irq;
    wire [7:0]  cnt;
    integer     errors     = 0;
    integer     n_checks   = 0;
    integer     i;
    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // Fixed clock has period 8, pin period 16, inside a quarter of bus rate
    always @(posedge ref_clk_in) ph <= ph + 4'h1;
    mtm_modulo_timer uut (
        .ref_clk_in            (ref_clk_in),
        .rst_in                (rst_in),
        .clk_en_in             (ce),
        .avs_address_in        (adr),
        .avs_read_in           (rd),
        .avs_write_in          (wr),
        .avs_writedata_in      ({24'h0, wd}),
        .avs_byteenable_in     (be),
        .fixed_freq_clock_in   (ph[2]),
        .external_count_pin_in (ph[3]),
        .debug_active_in       (dbg),
        .avs_readdata_out      (rdat),
        .avs_waitrequest_out   (wreq),
        .overflow_irq_out      (irq),
        .count_value_out       (cnt)
    );
    task complete_run;
        begin
            $display("checks %0d errors %0d", n_checks, errors);
            if (errors == 0 && n_checks > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    task fail;
        begin
            errors = errors + 1;
            $display("[ERR] %0t wait timed out", $time);
            complete_run;
        end
    endtask
    task chk(input reg [7:0] g, input reg [7:0] e);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("[ERR] %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    task rng(input reg [7:0] g, input reg [7:0] lo, input reg [7:0] hi);
        begin
            n_checks = n_checks + 1;
            if ((g >= lo && g <= hi) !== 1'b1) begin
                errors = errors + 1;
                $display("[ERR] %0t got %h outside %h..%h", $time, g, lo, hi);
            end
        end
    endtask
    // Holds the request until waitrequest is sampled low, then releases
    task xfer(input reg r, input reg [3:0] a, input reg [7:0] d);
        integer k;
        begin
            adr <= a;
            wd <= d;
            rd <= r;
            wr <= ~r;
            k = 0;
            @(posedge ref_clk_in);
            while (wreq !== 1'b0 && k < 50) begin
                @(posedge ref_clk_in);
                k = k + 1;
            end
            if (k == 50) fail;
            v = rdat[7:0];
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge ref_clk_in);
        end
    endtask
    task rc(input reg [3:0] a, input reg [7:0] e);
        begin
            xfer(1'b1, a, 8'h00);
            chk(v, e);
        end
    endtask
    task rr(input reg [3:0] a, input reg [7:0] lo, input reg [7:0] hi);
        begin
            xfer(1'b1, a, 8'h00);
            rng(v, lo, hi);
        end
    endtask
    task wirq(input integer n);
        integer k;
        begin
            k = 0;
            while (irq !== 1'b1 && k < n) begin
                @(posedge ref_clk_in);
                k = k + 1;
            end
            if (k == n) fail;
        end
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        rc(4'h0, 8'h10);
        rc(4'h4, 8'h00);
        rc(4'hc, 8'h00);
        xfer(1'b0, 4'h8, 8'h55);
        xfer(1'b0, 4'h2, 8'h77);
        rc(4'h8, 8'h00);
        rc(4'h2, 8'h00);
        xfer(1'b0, 4'h4, 8'hff);
        rc(4'h4, 8'h3f);
        be <= 4'he;
        xfer(1'b0, 4'h4, 8'h00);
        be <= 4'hf;
        rc(4'h4, 8'h3f);
        $display("test registers done");
        for (i = 0; i < 13; i = i + 1) begin
            xfer(1'b0, 4'h0, 8'h30);
            xfer(1'b0, 4'h4, i < 10 ? i[7:0] : {2'h0, i[1:0] - 2'h1, 4'h0});
            xfer(1'b0, 4'h0, 8'h00);
            repeat (i < 10 ? (1 << (i > 8 ? 8 : i)) * 8 : 128) @(posedge ref_clk_in);
            xfer(1'b0, 4'h0, 8'h10);
            rr(4'h8, i == 10 ? 8'd15 : 8'd7, i == 10 ? 8'd18 : 8'd12);
            rc(4'h8, v);
            chk(cnt, v);
        end
        $display("test rates done");
        xfer(1'b0, 4'h4, 8'h00);
        xfer(1'b0, 4'h0, 8'h00);
        repeat (20) @(posedge ref_clk_in);
        xfer(1'b0, 4'h4, 8'h18);
        rr(4'h8, 8'd25, 8'd60);
        dbg <= 1'b1;
        xfer(1'b0, 4'h4, 8'h00);
        repeat (5) @(posedge ref_clk_in);
        xfer(1'b1, 4'h8, 8'h00);
        repeat (10) @(posedge ref_clk_in);
        rc(4'h8, v);
        xfer(1'b0, 4'hc, 8'h00);
        rc(4'h8, 8'h00);
        dbg <= 1'b0;
        repeat (10) @(posedge ref_clk_in);
        rr(4'h8, 8'd5, 8'd14);
        // A frozen enable must hold the count while the bus is idle
        ce <= 1'b0;
        repeat (40) @(posedge ref_clk_in);
        ce <= 1'b1;
        rr(4'h8, v + 8'd1, v + 8'd8);
        $display("test hold done");
        xfer(1'b0, 4'hc, 8'h03);
        xfer(1'b0, 4'h0, 8'h40);
        wirq(100);
        for (i = 0; i < 4; i = i + 1) begin
            rr(4'h8, 8'h00, 8'h03);
        end
        rc(4'h0, 8'hc0);
        repeat (8) @(posedge ref_clk_in);
        xfer(1'b0, 4'h0, 8'h40);
        rc(4'h0, 8'hc0);
        xfer(1'b0, 4'h0, 8'hd0);
        rc(4'h0, 8'hd0);
        xfer(1'b0, 4'h0, 8'h50);
        rc(4'h0, 8'h50);
        chk({7'h0, irq}, 8'h00);
        xfer(1'b0, 4'hc, 8'h00);
        xfer(1'b0, 4'h0, 8'h40);
        wirq(300);
        xfer(1'b0, 4'h0, 8'h30);
        rc(4'h0, 8'h10);
        rc(4'h8, 8'h00);
        $display("test overflow done");
        complete_run;
    end
endmodule // mtm_modulo_timer_tb
